/* verilog/power_bank_consts.svh */
// Offsets, field positions, reset values and timing of the power bank.
// Assumes it is included by bare name and that the clock runs at 50 MHz.
`ifndef POWER_BANK_CONSTS_SVH
`define POWER_BANK_CONSTS_SVH
`define RAW_TOTAL_ACTIVE_POWER_IDX 10'h102
`define RAW_TOTAL_REACTIVE_POWER_IDX 10'h103
`define RAW_FUND_ACTIVE_POWER_IDX 10'h107
`define RAW_FUND_REACTIVE_POWER_IDX 10'h108
`define INST_TOTAL_ACTIVE_POWER_IDX 10'h10b
`define INST_TOTAL_REACTIVE_POWER_IDX 10'h10c
`define INST_FUND_ACTIVE_POWER_IDX 10'h110
`define INST_FUND_REACTIVE_POWER_IDX 10'h111
`define AVG_TOTAL_ACTIVE_POWER_IDX 10'h119
`define AVG_TOTAL_REACTIVE_POWER_IDX 10'h11a
`define AVG_FUND_ACTIVE_POWER_IDX 10'h11f
`define AVG_FUND_REACTIVE_POWER_IDX 10'h120
`define CURRENT_DC_BIAS_PRESET_IDX 10'h123
`define VOLTAGE_DC_BIAS_PRESET_IDX 10'h124
`define FUND_CURRENT_RMS_GAIN_IDX 10'h126
`define FUND_VOLTAGE_RMS_GAIN_IDX 10'h12b
`define TOTAL_CURRENT_RMS_GAIN_IDX 10'h12c
`define TOTAL_VOLTAGE_RMS_GAIN_IDX 10'h132
`define CTRL_IDX 10'h140
`define STATUS_IDX 10'h141
`define CTRL_SLOW_CLK_BIT 0
`define CTRL_SOFT_RESET_BIT 1
`define STATUS_RAW_SETTLED_BIT 0
`define STATUS_AVG_SETTLED_BIT 1
`define STATUS_SLOW_CLK_BIT 2
`define CAL_RESET_VALUE 32'h0000_0000
`define CTRL_SLOW_CLK_RESET 1'b0
`define GAIN_FRAC_BITS 31
`define CLK_FREQ_HZ 50000000
`define TICK_PERIOD_MS 1
`define TICK_CYCLES (`CLK_FREQ_HZ / 1000 * `TICK_PERIOD_MS)
`define RAW_REFRESH_FAST_MS 160
`define RAW_SETTLE_FAST_MS 500
`define RAW_REFRESH_SLOW_MS 640
`define RAW_SETTLE_SLOW_MS 2000
`define AVG_REFRESH_FAST_MS 1280
`define AVG_SETTLE_FAST_MS 3000
`define AVG_REFRESH_SLOW_MS 5120
`define AVG_SETTLE_SLOW_MS 12000
`endif

/* verilog/power_bank_pkg.sv */
// Types shared by the power result and calibration register bank.
// Assumes nothing of its surroundings.
package power_bank_pkg;
  typedef logic signed [31:0] word_t;
  typedef struct packed {
    word_t raw_total_active_power;
    word_t raw_total_reactive_power;
    word_t raw_fund_active_power;
    word_t raw_fund_reactive_power;
    word_t inst_total_active_power;
    word_t inst_total_reactive_power;
    word_t inst_fund_active_power;
    word_t inst_fund_reactive_power;
    word_t avg_total_active_power;
    word_t avg_total_reactive_power;
    word_t avg_fund_active_power;
    word_t avg_fund_reactive_power;
  } power_set_t;
  typedef struct packed {
    word_t total_current;
    word_t total_voltage;
    word_t fund_current;
    word_t fund_voltage;
  } rms_set_t;
  typedef struct packed {
    word_t current;
    word_t voltage;
  } channel_pair_t;
endpackage

/* verilog/refresh_timer.sv */
// Millisecond interval timer: periodic refresh pulse and settled level.
// Assumes tick_i is a one-cycle pulse once per millisecond.
`timescale 1ns/1ps
`default_nettype none
module refresh_timer #(
  parameter int unsigned REFRESH_FAST_MS = 160,
  parameter int unsigned REFRESH_SLOW_MS = 640,
  parameter int unsigned SETTLE_FAST_MS = 500,
  parameter int unsigned SETTLE_SLOW_MS = 2000
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic restart_i,
  input wire logic slow_i,
  input wire logic tick_i,
  output logic refresh_o,
  output logic settled_o
);
  localparam int unsigned CNT_W = 14;
  logic [CNT_W-1:0] period_q;
  logic [CNT_W-1:0] elapsed_q;
  logic [CNT_W-1:0] period_lim;
  logic [CNT_W-1:0] settle_lim;
  logic period_end;

  assign period_lim = slow_i ? CNT_W'(REFRESH_SLOW_MS - 1) : CNT_W'(REFRESH_FAST_MS - 1);
  assign settle_lim = slow_i ? CNT_W'(SETTLE_SLOW_MS) : CNT_W'(SETTLE_FAST_MS);
  assign period_end = tick_i && (period_q >= period_lim);

  always_ff @(posedge clk_i) begin
    if (rst_i || restart_i) begin
      period_q <= '0;
      refresh_o <= 1'b0;
    end else begin
      refresh_o <= period_end;
      if (period_end) begin
        period_q <= '0;
      end else if (tick_i) begin
        period_q <= period_q + 1'b1;
      end
    end
  end

  // Settled stays low until the settle time has elapsed since the restart.
  always_ff @(posedge clk_i) begin
    if (rst_i || restart_i) begin
      elapsed_q <= '0;
      settled_o <= 1'b0;
    end else begin
      settled_o <= (elapsed_q >= settle_lim);
      if (tick_i && (elapsed_q < settle_lim)) begin
        elapsed_q <= elapsed_q + 1'b1;
      end
    end
  end

  refresh_due_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (period_end && !restart_i) |=> refresh_o)
    else $error("refresh pulse missing at end of period");
  settle_restart_a: assert property (@(posedge clk_i) disable iff (rst_i)
    restart_i |=> !settled_o [*2])
    else $error("settled flag high right after restart");
endmodule
`default_nettype wire

/* verilog/power_result_cal_regs.sv */
// Power result and calibration register bank behind a classic Wishbone slave.
// Assumes the metering datapath supplies power results, raw RMS and samples
// on clk_i, and that rx_reset_i comes asynchronously from the receive line.
//
// Overview of operation
// - At the fast measurement clock raw and instantaneous power refresh every 160 ms, settled by 500 ms.
// - At the slow measurement clock raw and instantaneous power refresh every 640 ms, settled by 2000 ms.
// - At the fast measurement clock averaged power refreshes every 1.28 s, settled by 3 s.
// - At the slow measurement clock averaged power refreshes every 5.12 s, settled by 12 s.
// - Every power result reads as a 32-bit two's-complement word.
// - Power-on, receive-line or software reset returns each calibration register to default.
// - The current channel loses its DC offset by the current bias preset, default zero.
// - The voltage channel loses its DC offset by the voltage bias preset, default zero.
// - Each RMS gain register means a signed fraction, its content over 2^31.
// - Each raw RMS value is scaled by one plus its own fractional gain.
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "power_bank_consts.svh"
module power_result_cal_regs #(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES,
  parameter int unsigned RAW_REFRESH_FAST_MS = `RAW_REFRESH_FAST_MS,
  parameter int unsigned RAW_REFRESH_SLOW_MS = `RAW_REFRESH_SLOW_MS,
  parameter int unsigned RAW_SETTLE_FAST_MS = `RAW_SETTLE_FAST_MS,
  parameter int unsigned RAW_SETTLE_SLOW_MS = `RAW_SETTLE_SLOW_MS,
  parameter int unsigned AVG_REFRESH_FAST_MS = `AVG_REFRESH_FAST_MS,
  parameter int unsigned AVG_REFRESH_SLOW_MS = `AVG_REFRESH_SLOW_MS,
  parameter int unsigned AVG_SETTLE_FAST_MS = `AVG_SETTLE_FAST_MS,
  parameter int unsigned AVG_SETTLE_SLOW_MS = `AVG_SETTLE_SLOW_MS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [11:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic ack_o,
  output logic [31:0] dat_o,
  input wire logic rx_reset_i,
  input wire power_bank_pkg::power_set_t power_i,
  input wire power_bank_pkg::rms_set_t rms_raw_i,
  input wire power_bank_pkg::channel_pair_t sample_i,
  output power_bank_pkg::rms_set_t rms_cal_o,
  output power_bank_pkg::channel_pair_t sample_dc_free_o
);
  localparam int unsigned NUM_PWR = 12;
  localparam int unsigned NUM_RAW = 8;
  localparam int unsigned NUM_CAL = 6;
  localparam int unsigned TICK_W = 16;
  localparam logic [2:0] CAL_I_BIAS = 3'h0;
  localparam logic [2:0] CAL_U_BIAS = 3'h1;
  localparam logic [2:0] CAL_FUND_I = 3'h2;
  localparam logic [2:0] CAL_FUND_U = 3'h3;
  localparam logic [2:0] CAL_TOTAL_I = 3'h4;
  localparam logic [2:0] CAL_TOTAL_U = 3'h5;

  power_bank_pkg::word_t pwr_q [NUM_PWR];
  power_bank_pkg::word_t pwr_in [NUM_PWR];
  power_bank_pkg::word_t cal_q [NUM_CAL];
  logic [9:0] idx;
  logic req;
  logic wr_en;
  logic pwr_hit;
  logic [3:0] pwr_sel;
  logic cal_hit;
  logic [2:0] cal_sel;
  logic [31:0] rd_data;
  logic slow_clk_q;
  logic soft_rst_q;
  logic mode_chg_q;
  logic cal_rst;
  logic restart;
  logic rx_meta_q;
  logic rx_s2_q;
  logic rx_s3_q;
  logic rx_reset_q;
  logic [TICK_W-1:0] tick_cnt_q;
  logic tick_q;
  logic raw_refresh;
  logic avg_refresh;
  logic raw_settled;
  logic avg_settled;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction

  // Gain S is a fraction of 2^31, so the product is shifted back by 31 bits.
  function automatic power_bank_pkg::word_t scale(input power_bank_pkg::word_t v,
                                                  input power_bank_pkg::word_t s);
    logic signed [63:0] p;
    p = v * s;
    return v + power_bank_pkg::word_t'(p >>> `GAIN_FRAC_BITS);
  endfunction

  assign pwr_in[0] = power_i.raw_total_active_power;
  assign pwr_in[1] = power_i.raw_total_reactive_power;
  assign pwr_in[2] = power_i.raw_fund_active_power;
  assign pwr_in[3] = power_i.raw_fund_reactive_power;
  assign pwr_in[4] = power_i.inst_total_active_power;
  assign pwr_in[5] = power_i.inst_total_reactive_power;
  assign pwr_in[6] = power_i.inst_fund_active_power;
  assign pwr_in[7] = power_i.inst_fund_reactive_power;
  assign pwr_in[8] = power_i.avg_total_active_power;
  assign pwr_in[9] = power_i.avg_total_reactive_power;
  assign pwr_in[10] = power_i.avg_fund_active_power;
  assign pwr_in[11] = power_i.avg_fund_reactive_power;

  assign idx = adr_i[11:2];
  assign req = cyc_i && stb_i && !ack_o;
  // A write takes effect at the edge where the master sees ack high.
  assign wr_en = cyc_i && stb_i && we_i && ack_o;
  assign cal_rst = soft_rst_q || rx_reset_q;
  assign restart = cal_rst || mode_chg_q;

  always_comb begin
    pwr_hit = 1'b1;
    pwr_sel = 4'h0;
    case (idx)
      `RAW_TOTAL_ACTIVE_POWER_IDX: pwr_sel = 4'h0;
      `RAW_TOTAL_REACTIVE_POWER_IDX: pwr_sel = 4'h1;
      `RAW_FUND_ACTIVE_POWER_IDX: pwr_sel = 4'h2;
      `RAW_FUND_REACTIVE_POWER_IDX: pwr_sel = 4'h3;
      `INST_TOTAL_ACTIVE_POWER_IDX: pwr_sel = 4'h4;
      `INST_TOTAL_REACTIVE_POWER_IDX: pwr_sel = 4'h5;
      `INST_FUND_ACTIVE_POWER_IDX: pwr_sel = 4'h6;
      `INST_FUND_REACTIVE_POWER_IDX: pwr_sel = 4'h7;
      `AVG_TOTAL_ACTIVE_POWER_IDX: pwr_sel = 4'h8;
      `AVG_TOTAL_REACTIVE_POWER_IDX: pwr_sel = 4'h9;
      `AVG_FUND_ACTIVE_POWER_IDX: pwr_sel = 4'ha;
      `AVG_FUND_REACTIVE_POWER_IDX: pwr_sel = 4'hb;
      default: pwr_hit = 1'b0;
    endcase
  end

  always_comb begin
    cal_hit = 1'b1;
    cal_sel = CAL_I_BIAS;
    case (idx)
      `CURRENT_DC_BIAS_PRESET_IDX: cal_sel = CAL_I_BIAS;
      `VOLTAGE_DC_BIAS_PRESET_IDX: cal_sel = CAL_U_BIAS;
      `FUND_CURRENT_RMS_GAIN_IDX: cal_sel = CAL_FUND_I;
      `FUND_VOLTAGE_RMS_GAIN_IDX: cal_sel = CAL_FUND_U;
      `TOTAL_CURRENT_RMS_GAIN_IDX: cal_sel = CAL_TOTAL_I;
      `TOTAL_VOLTAGE_RMS_GAIN_IDX: cal_sel = CAL_TOTAL_U;
      default: cal_hit = 1'b0;
    endcase
  end

  // Unmapped offsets read as zero and ignore writes.
  always_comb begin
    rd_data = '0;
    if (pwr_hit) begin
      rd_data = pwr_q[pwr_sel];
    end else if (cal_hit) begin
      rd_data = cal_q[cal_sel];
    end else if (idx == `CTRL_IDX) begin
      rd_data[`CTRL_SLOW_CLK_BIT] = slow_clk_q;
    end else if (idx == `STATUS_IDX) begin
      rd_data[`STATUS_RAW_SETTLED_BIT] = raw_settled;
      rd_data[`STATUS_AVG_SETTLED_BIT] = avg_settled;
      rd_data[`STATUS_SLOW_CLK_BIT] = slow_clk_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= '0;
    end else begin
      ack_o <= req;
      if (req && !we_i) begin
        dat_o <= rd_data;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slow_clk_q <= `CTRL_SLOW_CLK_RESET;
      soft_rst_q <= 1'b0;
      mode_chg_q <= 1'b0;
    end else begin
      soft_rst_q <= wr_en && (idx == `CTRL_IDX) && sel_i[0] && dat_i[`CTRL_SOFT_RESET_BIT];
      mode_chg_q <= 1'b0;
      if (wr_en && (idx == `CTRL_IDX) && sel_i[0]) begin
        slow_clk_q <= dat_i[`CTRL_SLOW_CLK_BIT];
        mode_chg_q <= (dat_i[`CTRL_SLOW_CLK_BIT] != slow_clk_q);
      end
    end
  end

  // The receive-line reset is a pin; it counts once two later stages agree.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_meta_q <= 1'b0;
      rx_s2_q <= 1'b0;
      rx_s3_q <= 1'b0;
      rx_reset_q <= 1'b0;
    end else begin
      rx_meta_q <= rx_reset_i;
      rx_s2_q <= rx_meta_q;
      rx_s3_q <= rx_s2_q;
      if (rx_s2_q == rx_s3_q) begin
        rx_reset_q <= rx_s2_q;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || cal_rst) begin
      for (int i = 0; i < NUM_CAL; i++) begin
        cal_q[i] <= `CAL_RESET_VALUE;
      end
    end else if (wr_en && cal_hit) begin
      cal_q[cal_sel] <= merge(cal_q[cal_sel], dat_i, sel_i);
    end
  end

  // A refresh from the datapath wins over a host write in the same cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_PWR; i++) begin
        pwr_q[i] <= '0;
      end
    end else begin
      if (wr_en && pwr_hit) begin
        pwr_q[pwr_sel] <= merge(pwr_q[pwr_sel], dat_i, sel_i);
      end
      for (int i = 0; i < NUM_PWR; i++) begin
        if ((i < NUM_RAW) ? raw_refresh : avg_refresh) begin
          pwr_q[i] <= pwr_in[i];
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (tick_cnt_q >= TICK_W'(TICK_CYCLES - 1)) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  refresh_timer #(
    .REFRESH_FAST_MS(RAW_REFRESH_FAST_MS),
    .REFRESH_SLOW_MS(RAW_REFRESH_SLOW_MS),
    .SETTLE_FAST_MS(RAW_SETTLE_FAST_MS),
    .SETTLE_SLOW_MS(RAW_SETTLE_SLOW_MS)
  ) raw_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .restart_i(restart),
    .slow_i(slow_clk_q),
    .tick_i(tick_q),
    .refresh_o(raw_refresh),
    .settled_o(raw_settled)
  );

  refresh_timer #(
    .REFRESH_FAST_MS(AVG_REFRESH_FAST_MS),
    .REFRESH_SLOW_MS(AVG_REFRESH_SLOW_MS),
    .SETTLE_FAST_MS(AVG_SETTLE_FAST_MS),
    .SETTLE_SLOW_MS(AVG_SETTLE_SLOW_MS)
  ) avg_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .restart_i(restart),
    .slow_i(slow_clk_q),
    .tick_i(tick_q),
    .refresh_o(avg_refresh),
    .settled_o(avg_settled)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rms_cal_o <= '0;
    end else begin
      rms_cal_o.total_current <= scale(rms_raw_i.total_current, cal_q[CAL_TOTAL_I]);
      rms_cal_o.total_voltage <= scale(rms_raw_i.total_voltage, cal_q[CAL_TOTAL_U]);
      rms_cal_o.fund_current <= scale(rms_raw_i.fund_current, cal_q[CAL_FUND_I]);
      rms_cal_o.fund_voltage <= scale(rms_raw_i.fund_voltage, cal_q[CAL_FUND_U]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sample_dc_free_o <= '0;
    end else begin
      sample_dc_free_o.current <= sample_i.current - cal_q[CAL_I_BIAS];
      sample_dc_free_o.voltage <= sample_i.voltage - cal_q[CAL_U_BIAS];
    end
  end

  ack_single_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  ack_timing_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && !ack_o) |=> ack_o)
    else $error("ack not given one cycle after request");
  cal_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cal_rst |=> (cal_q[0] == 0 && cal_q[1] == 0 && cal_q[2] == 0
                 && cal_q[3] == 0 && cal_q[4] == 0 && cal_q[5] == 0))
    else $error("calibration register not cleared by reset");
  cal_store_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_en && cal_hit && sel_i == 4'hf && !cal_rst)
      |=> cal_q[$past(cal_sel)] == $past(dat_i))
    else $error("calibration write not stored whole");
  cal_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !we_i && cal_hit) |=> ack_o && dat_o == $past(cal_q[cal_sel]))
    else $error("calibration read back differs");
  raw_capture_a: assert property (@(posedge clk_i) disable iff (rst_i)
    raw_refresh |=> (pwr_q[0] == $past(pwr_in[0]) && pwr_q[7] == $past(pwr_in[7])))
    else $error("raw power not captured on refresh");
  avg_capture_a: assert property (@(posedge clk_i) disable iff (rst_i)
    avg_refresh |=> (pwr_q[8] == $past(pwr_in[8]) && pwr_q[11] == $past(pwr_in[11])))
    else $error("averaged power not captured on refresh");
  bias_current_a: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> sample_dc_free_o.current == $past(sample_i.current) - $past(cal_q[0]))
    else $error("current offset not removed");
  bias_voltage_a: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> sample_dc_free_o.voltage == $past(sample_i.voltage) - $past(cal_q[1]))
    else $error("voltage offset not removed");
  rms_unity_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (cal_q[CAL_TOTAL_I] == 0) |=> rms_cal_o.total_current == $past(rms_raw_i.total_current))
    else $error("zero gain changed the RMS value");
  rms_null_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (cal_q[CAL_FUND_U] == 32'h8000_0000) |=> rms_cal_o.fund_voltage == 0)
    else $error("gain of minus one did not null the RMS value");
endmodule
`default_nettype wire

/* verification/test_power_result_cal_regs.sv */
// Self-checking testbench for the power result and calibration register bank.
// Assumes the package and the design files are compiled first; TICK_CYCLES is shortened to 4.
`timescale 1ns/1ps
`default_nettype none
module test_power_result_cal_regs;
  localparam int TK = 4;
  localparam logic [9:0] PIDX [12] = '{10'h102, 10'h103, 10'h107, 10'h108, 10'h10b, 10'h10c,
    10'h110, 10'h111, 10'h119, 10'h11a, 10'h11f, 10'h120};
  localparam logic [9:0] CIDX [6] = '{10'h123, 10'h124, 10'h126, 10'h12b, 10'h12c, 10'h132};
  localparam logic [9:0] CTRL = 10'h140;
  localparam logic [9:0] STAT = 10'h141;
  localparam logic [9:0] NONE = 10'h3ff;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic rx_reset_i = 1'b0;
  logic [11:0] adr_i = 12'h000;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0000_0000;
  logic ack_o;
  logic [31:0] dat_o;
  power_bank_pkg::power_set_t power_i;
  power_bank_pkg::power_set_t pw_a;
  power_bank_pkg::power_set_t pw_b;
  power_bank_pkg::rms_set_t rms_raw_i;
  power_bank_pkg::rms_set_t rms_cal_o;
  power_bank_pkg::channel_pair_t sample_i;
  power_bank_pkg::channel_pair_t sample_dc_free_o;
  int err_total = 0;
  int total_checks = 0;
  logic [31:0] seed = 32'h05d9bd38;
  logic [31:0] cal [6];
  logic [31:0] q;

  power_result_cal_regs #(.TICK_CYCLES(TK)) i_power_result_cal_regs (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .we_i(we_i),
    .adr_i(adr_i),
    .sel_i(sel_i),
    .dat_i(dat_i),
    .ack_o(ack_o),
    .dat_o(dat_o),
    .rx_reset_i(rx_reset_i),
    .power_i(power_i),
    .rms_raw_i(rms_raw_i),
    .sample_i(sample_i),
    .rms_cal_o(rms_cal_o),
    .sample_dc_free_o(sample_dc_free_o)
  );

  always #10 clk_i = ~clk_i;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Calibrated RMS: v scaled by one plus the gain taken as a fraction of 2^31.
  function automatic logic [31:0] gain_exp(input logic [31:0] v, input logic [31:0] s);
    longint p;
    p = longint'($signed(v)) * longint'($signed(s));
    p = p >>> 31;
    return v + p[31:0];
  endfunction

  task automatic test_done();
    if (err_total == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One classic cycle; the request holds until ack is sampled high.
  task automatic wb(input logic w, input logic [9:0] idx, input logic [31:0] d,
                    input logic [3:0] s, output logic [31:0] r);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {idx, 2'b00};
    dat_i <= d;
    sel_i <= s;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    r = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    if (ack_o !== 1'b1) begin
      err_total++;
      test_done();
    end
  endtask

  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, idx, d, 4'hf, r);
  endtask

  task automatic rd_chk(input logic [9:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    wb(1'b0, idx, 32'h0000_0000, 4'h0, r);
    chk_word(r, exp);
  endtask

  task automatic chk_power(input power_bank_pkg::power_set_t pw, input int lo, input int hi);
    for (int k = lo; k <= hi; k++) begin
      rd_chk(PIDX[k], pw[383 - 32 * k -: 32]);
    end
  endtask

  task automatic wait_ms(input int ms);
    repeat (ms * TK) @(posedge clk_i);
  endtask

  initial begin
    for (int k = 0; k < 12; k++) begin
      pw_a[383 - 32 * k -: 32] = rnd();
      pw_b[383 - 32 * k -: 32] = rnd();
    end
    pw_a[383 -: 32] = 32'h8000_0000;
    power_i = pw_a;
    rms_raw_i = '0;
    sample_i = '0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(STAT, 32'h0000_0000);
    for (int k = 0; k < 6; k++) rd_chk(CIDX[k], 32'h0000_0000);
    rd_chk(NONE, 32'h0000_0000);
    // A host write to a power register stands until the next refresh replaces it.
    q = rnd();
    wr(PIDX[0], q);
    rd_chk(PIDX[0], q);
    wait_ms(200);
    chk_power(pw_a, 0, 7);
    chk_power('0, 8, 11);
    wait_ms(320);
    rd_chk(STAT, 32'h0000_0001);
    wait_ms(780);
    chk_power(pw_a, 8, 11);
    wait_ms(1720);
    rd_chk(STAT, 32'h0000_0003);
    for (int k = 0; k < 6; k++) begin
      cal[k] = rnd();
      wr(CIDX[k], cal[k]);
    end
    for (int k = 0; k < 6; k++) rd_chk(CIDX[k], cal[k]);
    wb(1'b1, CIDX[0], 32'hffff_ffff, 4'h5, q);
    cal[0] = cal[0] | 32'h00ff_00ff;
    rd_chk(CIDX[0], cal[0]);
    wb(1'b1, NONE, rnd(), 4'hf, q);
    rd_chk(NONE, 32'h0000_0000);
    // Corner gains of -1 and nearly +1 first, then random values.
    for (int i = 0; i < 6; i++) begin
      for (int k = 0; k < 6; k++) begin
        cal[k] = (i == 0) ? 32'h8000_0000 : (i == 1) ? 32'h7fff_ffff : rnd();
        wr(CIDX[k], cal[k]);
      end
      @(posedge clk_i);
      rms_raw_i <= {rnd(), rnd(), rnd(), rnd()};
      sample_i <= {rnd(), rnd()};
      @(posedge clk_i);
      @(posedge clk_i);
      chk_word(rms_cal_o.total_current, gain_exp(rms_raw_i.total_current, cal[4]));
      chk_word(rms_cal_o.total_voltage, gain_exp(rms_raw_i.total_voltage, cal[5]));
      chk_word(rms_cal_o.fund_current, gain_exp(rms_raw_i.fund_current, cal[2]));
      chk_word(rms_cal_o.fund_voltage, gain_exp(rms_raw_i.fund_voltage, cal[3]));
      chk_word(sample_dc_free_o.current, sample_i.current - cal[0]);
      chk_word(sample_dc_free_o.voltage, sample_i.voltage - cal[1]);
    end
    wr(CTRL, 32'h0000_0002);
    for (int k = 0; k < 6; k++) rd_chk(CIDX[k], 32'h0000_0000);
    rd_chk(CTRL, 32'h0000_0000);
    for (int k = 0; k < 6; k++) wr(CIDX[k], rnd());
    @(posedge clk_i);
    rx_reset_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    rx_reset_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    for (int k = 0; k < 6; k++) rd_chk(CIDX[k], 32'h0000_0000);
    wr(CTRL, 32'h0000_0001);
    power_i <= pw_b;
    rd_chk(CTRL, 32'h0000_0001);
    wait_ms(400);
    chk_power(pw_a, 0, 7);
    rd_chk(STAT, 32'h0000_0004);
    wait_ms(300);
    chk_power(pw_b, 0, 7);
    wait_ms(600);
    chk_power(pw_a, 8, 11);
    wait_ms(750);
    rd_chk(STAT, 32'h0000_0005);
    wait_ms(3150);
    chk_power(pw_b, 8, 11);
    rd_chk(STAT, 32'h0000_0005);
    test_done();
  end
endmodule
`default_nettype wire
